// ==== dv/cfgapr_host.sv ====
// host processor model issuing I/O port cycles
`timescale 1ns/1ns
`default_nettype none
module cfgapr_host (
  input  wire logic        ref_clk,  // bus clock
  output var  logic        ioValid,  // request strobe
  output var  logic        ioWrite,  // write flag
  output var  logic [15:0] ioAddr,   // I/O byte address
  output var  logic [3:0]  ioByteEn, // byte enables
  output var  logic [31:0] ioWdata   // write data
);
  initial
  begin
    ioValid = 1'b0;
    ioWrite = 1'b0;
    ioAddr = 16'h0000;
    ioByteEn = 4'h0;
    ioWdata = 32'h00000000;
  end

  // one request, answer lands at the edge that takes it
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
                    input logic [31:0] d);
  begin
    @(posedge ref_clk);
    ioValid <= 1'b1;
    ioWrite <= w;
    ioAddr <= a;
    ioByteEn <= be;
    ioWdata <= d;
    @(posedge ref_clk);
    ioValid <= 1'b0;
    // released bus must not keep showing the old value
    ioAddr <= ~a;
    ioWdata <= ~d;
    #1;
  end
  endtask
endmodule // cfgapr_host
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench for the configuration address port router
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  secBus = 8'h01;
  logic [7:0]  subBus = 8'h04;
  logic        ioValid, ioWrite, ioAck, ioPass, cfgStart;
  logic [15:0] ioAddr;
  logic [3:0]  ioByteEn;
  logic [2:0]  cfgRoute;
  logic [23:0] linkAddr;
  logic [31:0] ioWdata, ioRdata, hdrBytes6to9, selection;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  // last two entries run with the bridge window moved to 3..7
  localparam logic [31:0] SELS [10] = '{32'h80000000, 32'h80000800, 32'h80000100,
    32'h8000F8FC, 32'h8005A5A4, 32'h8001007C, 32'h80010800, 32'h80041234,
    32'h80041234, 32'h80020000};
  localparam logic [2:0] RTS [10] = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6,
    3'h6, 3'h4};

  always #5 ref_clk = ~ref_clk;

  cfgapr_host i_cfgapr_host (.ref_clk(ref_clk), .ioValid(ioValid), .ioWrite(ioWrite),
    .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWdata(ioWdata));

  cfg_address_port_router i_cfg_address_port_router (.ref_clk(ref_clk), .reset(reset),
    .ioValid(ioValid), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioByteEn(ioByteEn),
    .ioWdata(ioWdata), .secBus(secBus), .subBus(subBus), .ioAck(ioAck),
    .ioRdata(ioRdata), .ioPass(ioPass), .cfgStart(cfgStart), .cfgRoute(cfgRoute),
    .hdrBytes6to9(hdrBytes6to9), .linkAddr(linkAddr), .selection(selection));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
  begin
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  end
  endtask

  task automatic stop_test;
  begin
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // the whole run needs well under 200 cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      stop_test;
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(selection, 32'h00000000);
    i_cfgapr_host.io(1'b1, 16'h0CF8, 4'hF, 32'hFFFFFFFF);
    chk(32'(ioAck), 32'h00000001);
    chk(selection, 32'h80FFFFFC);
    i_cfgapr_host.io(1'b0, 16'h0CF8, 4'hF, 32'h00000000);
    chk(ioRdata, 32'h80FFFFFC);
    i_cfgapr_host.io(1'b1, 16'h0CF8, 4'h3, 32'h00000000);
    chk(32'({ioAck, ioPass}), 32'h00000001);
    chk(selection, 32'h80FFFFFC);
    i_cfgapr_host.io(1'b1, 16'h0080, 4'hF, 32'h00000000);
    chk(32'({ioAck, ioPass, cfgStart}), 32'h00000000);
    i_cfgapr_host.io(1'b1, 16'h0CF8, 4'hF, 32'h00000800);
    i_cfgapr_host.io(1'b0, 16'h0CFC, 4'hF, 32'h00000000);
    chk(32'({ioPass, cfgStart}), 32'h00000002);
    for (int i = 0; i < 10; i++)
    begin
      if (i == 8)
      begin
        @(posedge ref_clk);
        secBus <= 8'h03;
        subBus <= 8'h07;
      end
      i_cfgapr_host.io(1'b1, 16'h0CF8, 4'hF, SELS[i]);
      i_cfgapr_host.io(1'b1, 16'h0CFC, 4'hF, 32'h00000000);
      chk(32'({cfgStart, cfgRoute}), {28'h0, 1'b1, RTS[i]});
      chk(32'(linkAddr),
          {8'h00, (RTS[i] == 3'h4) ? SELS[i][23:16] : 8'h00, SELS[i][15:0]});
      chk(hdrBytes6to9, {SELS[i][15:0], SELS[i][23:16], 8'h00});
    end
    stop_test;
  end
endmodule // tb_top
`default_nettype wire

// ==== rtl/cfg_address_port_router.sv ====
// configuration address port with routing of data-window accesses
// Contract
// - the address port is four I/O bytes at 0CF8h and is claimed only for full doubleword access.
// - byte or word access to the port leaves it unchanged and goes to the chipset link as plain I/O.
// - bit 31 is a read/write enable resetting to 0 that gates configuration through the window.
// - bus 23:16, device 15:11, function 10:8, register 7:2 reset to zero; other bits reserved.
// - bus zero with device two or more gives a Type 0 cycle on the chipset link.
// - nonzero bus outside the bridge's secondary..subordinate range gives a link Type 1 cycle.
// - nonzero bus equal to the bridge secondary number gives a Type 0 request on the express port.
// - bus above secondary and up to subordinate gives a Type 1 request on the express port.
// - bus goes to header byte 8 bits 7:0 and to link address bits 23:16 for Type 1.
// - with bus zero, device 0 is the host bridge and device 1 the express bridge.
// - device goes to header byte 6 bits 7:3 and to link address bits 15:11.
// - cycles to internal functions with a nonzero function number are ignored.
// - function goes to header byte 6 bits 2:0 and to link address bits 10:8.
// - register goes to header byte 7 bits 7:2 and to link address bits 7:2.
// - with enable set, any data-window access starts a transaction to the held target.
// - an express Type 0 access with nonzero device number is master-aborted.
`timescale 1ns/1ns
`default_nettype none
module cfg_address_port_router (
  input  wire logic        ref_clk,      // 100 MHz clock
  input  wire logic        reset,        // async, active high
  input  wire logic        ioValid,      // one-cycle host I/O request
  input  wire logic        ioWrite,      // 1 write, 0 read
  input  wire logic [15:0] ioAddr,       // I/O byte address, dword aligned
  input  wire logic [3:0]  ioByteEn,     // byte enables
  input  wire logic [31:0] ioWdata,      // write data
  input  wire logic [7:0]  secBus,       // bridge secondary bus number
  input  wire logic [7:0]  subBus,       // bridge subordinate bus number
  output var  logic        ioAck,        // port claimed, one-cycle pulse
  output var  logic [31:0] ioRdata,      // port read data, valid with ioAck
  output var  logic        ioPass,       // pulse: forward as plain I/O on link
  output var  logic        cfgStart,     // pulse: configuration transaction routed
  output var  logic [2:0]  cfgRoute,     // route code, held
  output var  logic [31:0] hdrBytes6to9, // header bytes 6,7,8 and pad, held
  output var  logic [23:0] linkAddr,     // link address bits 23:0, held
  output var  logic [31:0] selection     // current port contents
);

  typedef struct packed {
    logic [31:0] sel;
    logic        ack;
    logic [31:0] rdata;
    logic        pass;
    logic        start;
    logic [2:0]  route;
    logic [31:0] hdr;
    logic [23:0] addr;
  } cfgapr_state_t;

  cfgapr_state_t st;
  cfgapr_state_t next_st;

  // route decision from the held fields; used for routing and checks
  function automatic cfgapr_pkg::cfgapr_route_t routeOf(
    input logic [31:0] s,
    input logic [7:0]  sb,
    input logic [7:0]  ub
  );
    logic [7:0] b;
    logic [4:0] d;
    logic [2:0] f;
    b = s[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO];
    d = s[cfgapr_pkg::DEV_HI:cfgapr_pkg::DEV_LO];
    f = s[cfgapr_pkg::FN_HI:cfgapr_pkg::FN_LO];
    if (b == cfgapr_pkg::BUS_ZERO)
    begin
      if (d == cfgapr_pkg::DEV_HOST || d == cfgapr_pkg::DEV_PEXBRIDGE)
      begin
        if (f != cfgapr_pkg::FN_ZERO)
          routeOf = cfgapr_pkg::RT_NONE;
        else if (d == cfgapr_pkg::DEV_HOST)
          routeOf = cfgapr_pkg::RT_INT_HOST;
        else
          routeOf = cfgapr_pkg::RT_INT_PEXB;
      end
      else
        routeOf = cfgapr_pkg::RT_LINK_T0;
    end
    else if (b == sb)
    begin
      // only device 0 lives across the express link
      if (d != cfgapr_pkg::DEV_HOST)
        routeOf = cfgapr_pkg::RT_ABORT;
      else
        routeOf = cfgapr_pkg::RT_PEX_T0;
    end
    else if (b > sb && b <= ub)
      routeOf = cfgapr_pkg::RT_PEX_T1;
    else
      routeOf = cfgapr_pkg::RT_LINK_T1;
  endfunction

  logic isAddrPort;
  logic isDataPort;
  logic fullDword;
  logic cfgOn;
  cfgapr_pkg::cfgapr_route_t rt;

  always_comb
  begin
    isAddrPort = (ioAddr == cfgapr_pkg::ADDR_PORT);
    isDataPort = (ioAddr == cfgapr_pkg::DATA_PORT);
    fullDword  = (ioByteEn == cfgapr_pkg::BE_DWORD);
    cfgOn      = st.sel[cfgapr_pkg::EN_BIT];
    rt         = routeOf(st.sel, secBus, subBus);
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.pass  = 1'b0;
    next_st.start = 1'b0;
    if (ioValid && isAddrPort)
    begin
      if (fullDword)
      begin
        next_st.ack   = 1'b1;
        next_st.rdata = st.sel;
        if (ioWrite)
          next_st.sel = ioWdata & cfgapr_pkg::SEL_WMASK;
      end
      else
        next_st.pass = 1'b1;
    end
    else if (ioValid && isDataPort)
    begin
      if (cfgOn)
      begin
        next_st.start = 1'b1;
        next_st.route = rt;
        next_st.hdr   = {HDRB6(st.sel),
                         st.sel[cfgapr_pkg::REG_HI:cfgapr_pkg::REG_LO],
                         cfgapr_pkg::HDR_BYTE_PAD,
                         st.sel[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO],
                         8'h00};
        next_st.addr  = st.sel[cfgapr_pkg::BUS_HI:0] & 24'hFFFFFC;
        if (rt != cfgapr_pkg::RT_LINK_T1)
          next_st.addr[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO] = 8'h00;
      end
      else
        next_st.pass = 1'b1;
    end
  end

  // header byte 6: device in 7:3, function in 2:0
  function automatic logic [7:0] HDRB6(input logic [31:0] s);
    HDRB6 = {s[cfgapr_pkg::DEV_HI:cfgapr_pkg::DEV_LO],
             s[cfgapr_pkg::FN_HI:cfgapr_pkg::FN_LO]};
  endfunction

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st       <= '0;
      st.sel   <= cfgapr_pkg::SEL_RESET;
    end
    else
      st <= next_st;
  end

  always_comb
  begin
    ioAck        = st.ack;
    ioRdata      = st.rdata;
    ioPass       = st.pass;
    cfgStart     = st.start;
    cfgRoute     = st.route;
    hdrBytes6to9 = st.hdr;
    linkAddr     = st.addr;
    selection    = st.sel;
  end

  property p_dword_write;
    @(posedge ref_clk) disable iff (reset)
      (ioValid && ioWrite && isAddrPort && fullDword)
        |=> (selection == ($past(ioWdata) & cfgapr_pkg::SEL_WMASK)) && ioAck;
  endproperty
  a_dword_write: assert property (p_dword_write)
    else $error("dword write did not load port");

  a_narrow_pass: assert property (@(posedge ref_clk) disable iff (reset)
    (ioValid && isAddrPort && !fullDword) |=> ioPass && !ioAck && $stable(selection))
    else $error("narrow access altered port or not forwarded");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (selection & ~cfgapr_pkg::SEL_WMASK) == 32'h0000_0000)
    else $error("reserved bits set");

  sequence s_win_on;
    ioValid && isDataPort && cfgOn;
  endsequence
  a_window_start: assert property (@(posedge ref_clk) disable iff (reset)
    s_win_on |=> cfgStart && cfgRoute == $past(rt))
    else $error("window access did not start transaction");

  a_window_off: assert property (@(posedge ref_clk) disable iff (reset)
    (ioValid && isDataPort && !cfgOn) |=> ioPass && !cfgStart)
    else $error("disabled window access not forwarded");

  // plain boolean antecedents: sequence and is poorly supported by free tools
  a_link_t0: assert property (@(posedge ref_clk) disable iff (reset)
    (ioValid && isDataPort && cfgOn
      && st.sel[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO] == cfgapr_pkg::BUS_ZERO
      && st.sel[cfgapr_pkg::DEV_HI:cfgapr_pkg::DEV_LO] > cfgapr_pkg::DEV_PEXBRIDGE)
      |=> cfgRoute == cfgapr_pkg::RT_LINK_T0)
    else $error("bus 0 external device not link type 0");

  a_fn_ignore: assert property (@(posedge ref_clk) disable iff (reset)
    (ioValid && isDataPort && cfgOn
      && st.sel[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO] == cfgapr_pkg::BUS_ZERO
      && st.sel[cfgapr_pkg::DEV_HI:cfgapr_pkg::DEV_LO] <= cfgapr_pkg::DEV_PEXBRIDGE
      && st.sel[cfgapr_pkg::FN_HI:cfgapr_pkg::FN_LO] != cfgapr_pkg::FN_ZERO)
      |=> cfgRoute == cfgapr_pkg::RT_NONE)
    else $error("internal nonzero function not ignored");

  a_pex_abort: assert property (@(posedge ref_clk) disable iff (reset)
    (ioValid && isDataPort && cfgOn
      && st.sel[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO] != cfgapr_pkg::BUS_ZERO
      && st.sel[cfgapr_pkg::BUS_HI:cfgapr_pkg::BUS_LO] == secBus
      && st.sel[cfgapr_pkg::DEV_HI:cfgapr_pkg::DEV_LO] != cfgapr_pkg::DEV_HOST)
      |=> cfgRoute == cfgapr_pkg::RT_ABORT)
    else $error("express type 0 nonzero device not aborted");

  a_hdr_map: assert property (@(posedge ref_clk) disable iff (reset)
    s_win_on |=> hdrBytes6to9[15:8] == $past(st.sel[23:16])
      && hdrBytes6to9[31:27] == $past(st.sel[15:11]))
    else $error("header fields misplaced");

endmodule // cfg_address_port_router
`default_nettype wire

// ==== rtl/cfgapr_pkg.sv ====
// constants for the configuration address port router
package cfgapr_pkg;
  localparam logic [15:0] ADDR_PORT      = 16'h0CF8;
  localparam logic [15:0] DATA_PORT      = 16'h0CFC;
  localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
  localparam logic [3:0]  BE_DWORD       = 4'hF;
  localparam int          EN_BIT         = 31;
  localparam int          BUS_HI         = 23;
  localparam int          BUS_LO         = 16;
  localparam int          DEV_HI         = 15;
  localparam int          DEV_LO         = 11;
  localparam int          FN_HI          = 10;
  localparam int          FN_LO          = 8;
  localparam int          REG_HI         = 7;
  localparam int          REG_LO         = 2;
  localparam logic [31:0] SEL_WMASK      = 32'h80FF_FFFC;
  localparam logic [4:0]  DEV_HOST       = 5'h00;
  localparam logic [4:0]  DEV_PEXBRIDGE  = 5'h01;
  localparam logic [2:0]  FN_ZERO        = 3'h0;
  localparam logic [7:0]  BUS_ZERO       = 8'h00;
  localparam logic [1:0]  HDR_BYTE_PAD   = 2'h0;
  // route codes
  typedef enum logic [2:0] {
    RT_NONE     = 3'b000,
    RT_INT_HOST = 3'b001,
    RT_INT_PEXB = 3'b010,
    RT_LINK_T0  = 3'b011,
    RT_LINK_T1  = 3'b100,
    RT_PEX_T0   = 3'b101,
    RT_PEX_T1   = 3'b110,
    RT_ABORT    = 3'b111
  } cfgapr_route_t;
endpackage
